// [sbc_charger_ctl.sv]
// smart charger command logic: bus slave on the link clock, registers and
// charger state on the system clock
// assumes comparator inputs are asynchronous levels and sda is open drain
//
// Behaviour
// - adapter above threshold sets status bit 15 and allows charging
// - input below battery plus margin: power fail, source switch off, bit 13
// - thermistor below presence fraction: battery present, bit 14, charging needs both set-points at minimum
// - no battery returns every command register to its reset value
// - no battery: float charge at fixed voltage, 128mA compliance
// - battery undervoltage caps current at 128mA with hysteresis, set-point kept
// - logic supply low: bus ignored, no charge, restart from reset
// - device is only a slave, answers master commands and queries
// - only word read and word write formats, sixteen data bits
// - master frames with start and stop; device detects both
// - only slave address 0b0001001 is acknowledged
// - word read of code 0x11 returns 0x09
// - mode word written with code 0x12, bit 0 is first byte lsb
// - word read of code 0x13 returns status word
// - overtemp halt enable returns to 1 when battery removed
// - overtemp and alarm flags clear on battery absent or restore bit; a hot event keeps overtemp set over restore
// - alarm flag also clears on new current or voltage set-point
// - word write: address, command, low, high, each acked low, then stop
// - word read: repeated start, low then high, master nacks high byte
// - voltage uses bits 14:4, clamps at 0x4800, stops below 0x0400
// - current uses bits 11:6, clamps above 0x0BC0, off below 0x0080
// - restore bit loads voltage 0xFFFF and current 0x00C0
// - charge suppress latch follows only mode bit 0
`include "sbc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sbc_charger_ctl (
    // system clock domain
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sys_ce,
    // serial link
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // comparators and charger commands
    input wire sbc_pkg::sbc_cmp_t cmp,
    output sbc_pkg::sbc_out_t drv
);
    sbc_pkg::sbc_cmp_t cmp_s;
    sbc_pkg::sbc_link_st_t st;
    logic link_rst;
    logic start_tgl, stop_tgl, start_seen, wr_tgl;
    logic [1:0] tgl_s, tgl_d;
    logic stop_edge, wr_edge, pend, commit;
    logic [7:0] shreg, cmd, wr_lo, wr_hi;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic is_read, tx_hi;
    logic [15:0] tx_word, status, status_l;
    logic [7:0] tx_byte;
    logic inhibit, halt_en, overtemp, alarm, uv;
    logic [15:0] vset, iset;
    logic clr_all, wr_mode, wr_volt, wr_cur, wr_alarm, restore, hot_evt;

    // voltage set-point to converter code
    function automatic logic [10:0] vclamp(input logic [15:0] v);
        if (v >= `SBC_V_FULL)
            return `SBC_VDAC_FULL;
        return v[14:4];
    endfunction : vclamp

    // current set-point to converter code
    function automatic logic [5:0] iclamp(input logic [15:0] i);
        if (i > `SBC_I_FULL)
            return `SBC_IDAC_FULL;
        return i[11:6];
    endfunction : iclamp

    // word returned for a read command
    function automatic logic [15:0] read_word(input logic [7:0] c, input logic [15:0] s);
        case (c)
            `SBC_CMD_SPEC: return `SBC_SPEC_WORD;
            `SBC_CMD_STAT: return s;
            default: return `SBC_UNMAPPED_WORD;
        endcase
    endfunction : read_word

    assign sda_out = 1'b0;

    // comparator pins into the system domain
    sbc_sync #(.WIDTH(8)) u_pin_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .ce(sys_ce),
        .d(cmp),
        .q(cmp_s)
    );

    // link events into the system domain
    sbc_sync #(.WIDTH(2)) u_evt_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .ce(sys_ce),
        .d({stop_tgl, wr_tgl}),
        .q(tgl_s)
    );

    // status word into the link domain
    sbc_sync #(.WIDTH(16)) u_stat_sync (
        .clk(scl_clk),
        .rst(link_rst),
        .ce(1'b1),
        .d(status),
        .q(status_l)
    );

    // link held in reset while the logic supply is low
    always_ff @(posedge sys_clk) begin
        link_rst <= sys_rst | cmp_s.vdd_low;
    end

    // start: sda falls while scl high
    always_ff @(negedge sda_in or posedge link_rst) begin
        if (link_rst)
            start_tgl <= 1'b0;
        else if (scl_clk)
            start_tgl <= ~start_tgl;
    end

    // stop: sda rises while scl high
    always_ff @(posedge sda_in or posedge link_rst) begin
        if (link_rst)
            stop_tgl <= 1'b0;
        else if (scl_clk)
            stop_tgl <= ~stop_tgl;
    end

    assign tx_byte = tx_hi ? tx_word[15:8] : tx_word[7:0];

    // link receiver and sequencer, sampling sda on rising scl
    always_ff @(posedge scl_clk or posedge link_rst) begin
        if (link_rst) begin
            st <= sbc_pkg::SBC_IDLE;
            start_seen <= 1'b0;
            shreg <= 8'h00;
            bit_cnt <= 3'h0;
            byte_idx <= 2'h0;
            is_read <= 1'b0;
            tx_hi <= 1'b0;
            tx_word <= 16'h0000;
            cmd <= 8'h00;
            wr_lo <= 8'h00;
            wr_hi <= 8'h00;
            wr_tgl <= 1'b0;
        end else if (start_seen != start_tgl) begin
            start_seen <= start_tgl;
            st <= sbc_pkg::SBC_ADDR;
            shreg <= {7'h00, sda_in};
            bit_cnt <= 3'h1;
        end else begin
            case (st)
                sbc_pkg::SBC_ADDR: begin
                    shreg <= {shreg[6:0], sda_in};
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        is_read <= sda_in;
                        // foreign addresses drop the frame
                        st <= (shreg[6:0] == `SBC_ADDR) ? sbc_pkg::SBC_ACK_A
                                                        : sbc_pkg::SBC_IDLE;
                    end
                end
                sbc_pkg::SBC_ACK_A: begin
                    bit_cnt <= 3'h0;
                    if (is_read) begin
                        st <= sbc_pkg::SBC_TX;
                        tx_hi <= 1'b0;
                        tx_word <= read_word(cmd, status_l);
                    end else begin
                        st <= sbc_pkg::SBC_RX;
                        byte_idx <= 2'h0;
                    end
                end
                sbc_pkg::SBC_RX: begin
                    shreg <= {shreg[6:0], sda_in};
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        st <= sbc_pkg::SBC_ACK_R;
                        case (byte_idx)
                            2'h0: cmd <= {shreg[6:0], sda_in};
                            2'h1: wr_lo <= {shreg[6:0], sda_in};
                            default: wr_hi <= {shreg[6:0], sda_in};
                        endcase
                    end
                end
                sbc_pkg::SBC_ACK_R: begin
                    bit_cnt <= 3'h0;
                    if (byte_idx == 2'h2) begin
                        wr_tgl <= ~wr_tgl;
                        st <= sbc_pkg::SBC_IDLE;
                    end else begin
                        byte_idx <= byte_idx + 2'h1;
                        st <= sbc_pkg::SBC_RX;
                    end
                end
                sbc_pkg::SBC_TX: begin
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7)
                        st <= sbc_pkg::SBC_TACK;
                end
                sbc_pkg::SBC_TACK: begin
                    bit_cnt <= 3'h0;
                    // master ack after low byte continues, nack ends
                    if (!sda_in && !tx_hi) begin
                        tx_hi <= 1'b1;
                        st <= sbc_pkg::SBC_TX;
                    end else begin
                        st <= sbc_pkg::SBC_IDLE;
                    end
                end
                default: st <= sbc_pkg::SBC_IDLE;
            endcase
        end
    end

    // sda driver, changing only while scl is low; never starts a frame
    always_ff @(negedge scl_clk or posedge link_rst) begin
        if (link_rst) begin
            sda_oe <= 1'b0;
        end else begin
            case (st)
                sbc_pkg::SBC_ACK_A, sbc_pkg::SBC_ACK_R: sda_oe <= 1'b1;
                sbc_pkg::SBC_TX: sda_oe <= ~tx_byte[~bit_cnt]; // msb first
                default: sda_oe <= 1'b0;
            endcase
        end
    end

    // event edges from the link
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            tgl_d <= 2'b00;
        else if (sys_ce)
            tgl_d <= tgl_s;
    end
    assign stop_edge = tgl_s[1] ^ tgl_d[1];
    assign wr_edge = tgl_s[0] ^ tgl_d[0];

    // a received word is applied at the stop that ends its frame; the stop
    // trails the last ack by less than one system clock, so both edges may
    // come out of the synchronisers together and must still commit
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            pend <= 1'b0;
        else if (sys_ce)
            pend <= (wr_edge | pend) & ~stop_edge;
    end
    assign commit = sys_ce & (pend | wr_edge) & stop_edge;

    // command decode; unknown codes fall through untouched
    assign wr_mode = commit && (cmd == `SBC_CMD_MODE);
    assign wr_volt = commit && (cmd == `SBC_CMD_VOLT);
    assign wr_cur = commit && (cmd == `SBC_CMD_CUR);
    assign wr_alarm = commit && (cmd == `SBC_CMD_ALARM);
    assign restore = wr_mode && wr_lo[`SBC_MODE_RESTORE];
    assign clr_all = sys_rst | cmp_s.vdd_low | ~cmp_s.battery_voltage_pin;
    assign hot_evt = cmp_s.thm_hot & ~cmp_s.thm_ur;

    // charge suppress latch
    always_ff @(posedge sys_clk) begin
        if (clr_all)
            inhibit <= 1'b0;
        else if (sys_ce && wr_mode)
            inhibit <= wr_lo[`SBC_MODE_INHIBIT];
    end

    // overtemperature halt enable
    always_ff @(posedge sys_clk) begin
        if (clr_all)
            halt_en <= `SBC_HALT_RST;
        else if (sys_ce && wr_mode)
            halt_en <= wr_hi[`SBC_MODE_HALT - 8];
    end

    // voltage and current set-points
    always_ff @(posedge sys_clk) begin
        if (clr_all) begin
            vset <= `SBC_VSET_RST;
            iset <= `SBC_ISET_RST;
        end else if (sys_ce) begin
            if (restore) begin
                vset <= `SBC_VSET_RESTORE;
                iset <= `SBC_ISET_RESTORE;
            end
            if (wr_volt)
                vset <= {wr_hi, wr_lo};
            if (wr_cur)
                iset <= {wr_hi, wr_lo};
        end
    end

    // latched overtemperature flag; a new hot event wins over restore
    always_ff @(posedge sys_clk) begin
        if (clr_all)
            overtemp <= 1'b0;
        else if (sys_ce && hot_evt)
            overtemp <= 1'b1;
        else if (sys_ce && restore)
            overtemp <= 1'b0;
    end

    // latched alarm block flag
    always_ff @(posedge sys_clk) begin
        if (clr_all)
            alarm <= 1'b0;
        else if (sys_ce && wr_alarm)
            alarm <= 1'b1;
        else if (sys_ce && (restore || wr_volt || wr_cur))
            alarm <= 1'b0;
    end

    // battery undervoltage with hysteresis
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            uv <= 1'b0;
        else if (sys_ce && cmp_s.battery_voltage_pin_uv)
            uv <= 1'b1;
        else if (sys_ce && cmp_s.battery_voltage_pin_ok)
            uv <= 1'b0;
    end

    // status word as read over the link
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status <= 16'h0000;
        end else if (sys_ce) begin
            status <= 16'h0000;
            status[`SBC_ST_ADAPTER] <= cmp_s.input_supply_sense_ok;
            status[`SBC_ST_BATTERY_VOLTAGE_PIN] <= cmp_s.battery_voltage_pin;
            status[`SBC_ST_PFAIL] <= cmp_s.pfail;
            status[`SBC_ST_ALARM] <= alarm;
            status[`SBC_ST_HALT] <= halt_en;
            status[`SBC_ST_OVERTEMP] <= overtemp;
            status[`SBC_ST_UNDERRANGE] <= cmp_s.thm_ur;
            status[`SBC_ST_INHIBIT] <= inhibit;
        end
    end

    // commands to the analog charger
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            drv <= '0;
        end else if (sys_ce) begin
            drv.float_mode <= ~cmp_s.battery_voltage_pin;
            drv.vdac <= cmp_s.battery_voltage_pin ? vclamp(vset) : `SBC_VDAC_FLOAT;
            drv.idac <= iclamp(iset);
            drv.current_cap <= ~cmp_s.battery_voltage_pin | uv;
            drv.source_switch_driver <= ~cmp_s.pfail & ~cmp_s.vdd_low;
            drv.charge_on <= cmp_s.input_supply_sense_ok & ~cmp_s.pfail & ~cmp_s.vdd_low & ~inhibit
                & ~(halt_en & overtemp)
                & (~cmp_s.battery_voltage_pin | (vset >= `SBC_V_MIN && iset >= `SBC_I_MIN));
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_adapter_bit: assert property (sys_ce ##1 sys_ce |-> status[`SBC_ST_ADAPTER] == $past(cmp_s.input_supply_sense_ok))
        else $error("adapter bit does not follow comparator");
    a_pfail_switch: assert property (sys_ce && cmp_s.pfail |=> !drv.source_switch_driver && !drv.charge_on)
        else $error("source switch on during power fail");
    a_battery_voltage_pin_bit: assert property (sys_ce ##1 sys_ce |-> status[`SBC_ST_BATTERY_VOLTAGE_PIN] == $past(cmp_s.battery_voltage_pin))
        else $error("battery bit does not follow thermistor");
    a_absent_reset: assert property (!cmp_s.battery_voltage_pin |=> vset == `SBC_VSET_RST && !inhibit && halt_en)
        else $error("registers not reset without battery");
    a_float_charge: assert property (sys_ce && !cmp_s.battery_voltage_pin |=> drv.vdac == `SBC_VDAC_FLOAT && drv.current_cap)
        else $error("float charge not commanded");
    a_uv_cap: assert property (sys_ce && cmp_s.battery_voltage_pin_uv ##1 sys_ce |=> drv.current_cap)
        else $error("undervoltage did not cap current");
    a_vdd_low: assert property (sys_ce && cmp_s.vdd_low |=> link_rst && !drv.charge_on)
        else $error("activity during supply undervoltage");
    a_flag_clear: assert property (restore && !hot_evt |=> !overtemp && !alarm)
        else $error("latched flags survive restore");
    a_alarm_clear: assert property (wr_volt || wr_cur |=> !alarm)
        else $error("alarm flag survives new set-point");
    a_restore_load: assert property (restore && !wr_volt && !clr_all |=> vset == `SBC_VSET_RESTORE && iset == `SBC_ISET_RESTORE)
        else $error("restore values not loaded");
    a_inhibit_hold: assert property (!wr_mode && !clr_all |=> inhibit == $past(inhibit))
        else $error("suppress latch changed by other command");
    a_vclamp_full: assert property (sys_ce && cmp_s.battery_voltage_pin && vset >= `SBC_V_FULL |=> drv.vdac == `SBC_VDAC_FULL)
        else $error("voltage code not clamped");
    a_addr_ack: assert property (@(posedge scl_clk) disable iff (link_rst) st == sbc_pkg::SBC_ACK_A |-> sda_oe)
        else $error("address not acknowledged");
    a_spec_word: assert property (@(posedge scl_clk) disable iff (link_rst)
        st == sbc_pkg::SBC_ACK_A && is_read && cmd == `SBC_CMD_SPEC && start_seen == start_tgl
        |=> tx_word == `SBC_SPEC_WORD)
        else $error("wrong specification word");

    c_mode_write: cover property (wr_mode);
    c_restore: cover property (restore);
    c_float: cover property (!cmp_s.battery_voltage_pin ##1 cmp_s.battery_voltage_pin);
    c_read_hi: cover property (@(posedge scl_clk) tx_hi && st == sbc_pkg::SBC_TACK);
endmodule : sbc_charger_ctl
`default_nettype wire

// [sbc_defs.svh]
// constants of the smart charger bus command logic: address, command codes,
// mode and status field positions, reset and restore values, set-point limits
// assumes inclusion by bare name from each design file that needs it
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// bus address and command codes
`define SBC_ADDR 7'h09
`define SBC_CMD_SPEC 8'h11
`define SBC_CMD_MODE 8'h12
`define SBC_CMD_STAT 8'h13
`define SBC_CMD_CUR 8'h14
`define SBC_CMD_VOLT 8'h15
`define SBC_CMD_ALARM 8'h16

// constant words
`define SBC_SPEC_WORD 16'h0009
`define SBC_UNMAPPED_WORD 16'h0000

// mode word bit positions
`define SBC_MODE_INHIBIT 0
`define SBC_MODE_RESTORE 2
`define SBC_MODE_HALT 10

// status word bit positions
`define SBC_ST_INHIBIT 0
`define SBC_ST_UNDERRANGE 8
`define SBC_ST_OVERTEMP 9
`define SBC_ST_HALT 10
`define SBC_ST_ALARM 12
`define SBC_ST_PFAIL 13
`define SBC_ST_BATTERY_VOLTAGE_PIN 14
`define SBC_ST_ADAPTER 15

// set-point and halt enable reset and restore values
`define SBC_VSET_RST 16'h0000
`define SBC_ISET_RST 16'h0000
`define SBC_VSET_RESTORE 16'hFFFF
`define SBC_ISET_RESTORE 16'h00C0
`define SBC_HALT_RST 1'b1

// set-point limits and converter codes
`define SBC_V_FULL 16'h4800
`define SBC_V_MIN 16'h0400
`define SBC_I_FULL 16'h0BC0
`define SBC_I_MIN 16'h0080
`define SBC_VDAC_FULL 11'h480
`define SBC_IDAC_FULL 6'h2F
`define SBC_VDAC_FLOAT 11'h479

`endif

// [sbc_pkg.sv]
// types of the smart charger bus command logic
// assumes no other package; constants live in sbc_defs.svh
package sbc_pkg;

    // synchronised comparator levels, one bit each
    typedef struct packed {
        logic input_supply_sense_ok;      // adapter above its presence threshold
        logic pfail;        // input below battery plus margin
        logic battery_voltage_pin;         // thermistor below presence fraction
        logic battery_voltage_pin_uv;      // battery below undervoltage threshold
        logic battery_voltage_pin_ok;      // battery above recovery threshold
        logic vdd_low;      // logic supply undervoltage
        logic thm_hot;      // thermistor in hot range
        logic thm_ur;       // thermistor underrange
    } sbc_cmp_t;

    // commands to the analog charger
    typedef struct packed {
        logic charge_on;
        logic float_mode;
        logic current_cap;
        logic source_switch_driver;
        logic [10:0] vdac;
        logic [5:0] idac;
    } sbc_out_t;

    // serial link states
    typedef enum logic [2:0] {
        SBC_IDLE, SBC_ADDR, SBC_ACK_A, SBC_RX, SBC_ACK_R, SBC_TX, SBC_TACK
    } sbc_link_st_t;

endpackage : sbc_pkg

// [sbc_sync.sv]
// two flip-flop synchroniser bank for independent level or toggle bits
// assumes each bit changes slowly compared to clk; bits are not coherent
`timescale 1ns/1ps
`default_nettype none
module sbc_sync #(
    parameter int WIDTH = 8
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sbc_sync
`default_nettype wire

// [sbc_host.sv]
// bus master model: frames word writes and word reads on the charger link
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module sbc_host (
    // bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    logic [6:0] addr = 7'h09; // target address, moved only by refusal
    // idle bus: clock parked high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit: data set while clock low, level taken at the rising edge
    task automatic bit_x(input logic b, output logic s);
        #3 sda_low = ~b;
        #3 scl = 1'b1;
        s = sda;
        #6 scl = 1'b0;
    endtask : bit_x
    // byte msb first, then the ninth bit; ack true when the line was low
    task automatic byte_x(input logic [7:0] b, input logic nak, output logic [7:0] g,
                          output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
            g[i] = s;
        end
        bit_x(nak, s);
        ack = ~s;
    endtask : byte_x
    // only this side ever opens a frame
    task automatic start;
        sda_low = 1'b1; // data falls while clock high
        #6 scl = 1'b0;
    endtask : start
    task automatic rstart;
        #3 sda_low = 1'b0;
        #3 scl = 1'b1;
        #3 start();
    endtask : rstart
    // stop, then the bus gap before the next frame
    task automatic stop;
        #3 sda_low = 1'b1;
        #3 scl = 1'b1;
        #3 sda_low = 1'b0; // data rises while clock high
        #1000;
    endtask : stop
    // word write: address, command, low byte, high byte
    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
        logic [7:0] g;
        logic a0, a1, a2, a3;
        start();
        byte_x({addr, 1'b0}, 1'b1, g, a0);
        byte_x(cmd, 1'b1, g, a1);
        byte_x(d[7:0], 1'b1, g, a2);
        byte_x(d[15:8], 1'b1, g, a3);
        stop();
        ok = a0 & a1 & a2 & a3;
    endtask : wr_word
    // word read: low byte acked, high byte refused
    task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
        logic [7:0] g;
        logic a0, a1, a2, x;
        start();
        byte_x({addr, 1'b0}, 1'b1, g, a0);
        byte_x(cmd, 1'b1, g, a1);
        rstart();
        byte_x({addr, 1'b1}, 1'b1, g, a2);
        byte_x(8'hFF, 1'b0, d[7:0], x);
        byte_x(8'hFF, 1'b1, d[15:8], x);
        stop();
        ok = a0 & a1 & a2;
    endtask : rd_word
endmodule : sbc_host
`default_nettype wire

// [tb.sv]
// self-checking bench for the charger command logic
// assumes sbc_pkg compiled first and sbc_host as the bus master
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end
module tb;
    typedef struct {
        logic [7:0] c;
        logic [7:0] cmd;
        logic [15:0] w;
        logic sw;
    } sbc_row_t;
    // comparators, read code, expected word, expected source switch
    sbc_row_t rows [5] = '{
        '{8'hA8, 8'h13, 16'hC400, 1'b1}, // adapter and battery
        '{8'hE8, 8'h13, 16'hE400, 1'b0}, // power fail
        '{8'h80, 8'h13, 16'h8400, 1'b1}, // no battery
        '{8'hA8, 8'h11, 16'h0009, 1'b1}, // version word
        '{8'hA8, 8'h20, 16'h0000, 1'b1}
    };
    logic sys_clk, sys_rst, sys_ce, scl, sda_low, sda_out, sda_oe, sda, ok;
    logic [15:0] rd;
    sbc_pkg::sbc_cmp_t cmp;
    sbc_pkg::sbc_out_t drv;
    int error_cnt = 0;
    int n_compared = 0;
    // open-drain data line with pull-up
    assign sda = ~sda_low & (sda_oe ? sda_out : 1'b1);
    sbc_charger_ctl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(sys_ce),
        .scl_clk(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .cmp(cmp), .drv(drv));
    sbc_host host (.scl(scl), .sda_low(sda_low), .sda(sda));
    // verdict and end of run
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask : tdone
    // comparator change, then time to pass the synchronisers
    task automatic set_cmp(input logic [7:0] c);
        @(posedge sys_clk);
        cmp <= c;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : set_cmp
    // write, then sample away from the clock edge
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.wr_word(c, d, ok);
        @(negedge sys_clk);
    endtask : wr
    task automatic rd_st;
        host.rd_word(8'h13, rd, ok);
    endtask : rd_st
    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // watchdog
    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        sys_ce = 1'b1;
        cmp = 8'hA8;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        set_cmp(8'hA8);
        `CHK("vdac reset", 11'h000, drv.vdac)
        foreach (rows[i]) begin
            set_cmp(rows[i].c);
            host.rd_word(rows[i].cmd, rd, ok);
            `CHK("read ack", 1'b1, ok)
            `CHK("read word", rows[i].w, rd)
            `CHK("source switch", rows[i].sw, drv.source_switch_driver)
        end
        tdone("rows");
        set_cmp(8'hA8);
        wr(8'h15, 16'h3000);
        wr(8'h14, 16'h0400);
        `CHK("write ack", 1'b1, ok)
        `CHK("vdac", 11'h300, drv.vdac)
        `CHK("idac", 6'h10, drv.idac)
        `CHK("charge on", 1'b1, drv.charge_on)
        wr(8'h15, 16'h5000);
        `CHK("vdac clamp", 11'h480, drv.vdac)
        wr(8'h15, 16'h03F0);
        `CHK("low voltage stop", 1'b0, drv.charge_on)
        wr(8'h15, 16'h3000);
        wr(8'h14, 16'h0C00);
        `CHK("idac clamp", 6'h2F, drv.idac)
        wr(8'h14, 16'h0040);
        `CHK("low current off", 1'b0, drv.charge_on)
        wr(8'h14, 16'h0400);
        wr(8'h30, 16'hFFFF);
        `CHK("unknown ack", 1'b1, ok)
        `CHK("unknown vdac", 11'h300, drv.vdac)
        tdone("setpoints");
        wr(8'h12, 16'h0401);
        rd_st();
        `CHK("suppress status", 16'hC401, rd)
        `CHK("suppress charge", 1'b0, drv.charge_on)
        wr(8'h15, 16'h3000);
        rd_st();
        `CHK("suppress kept", 1'b1, rd[0])
        wr(8'h12, 16'h0400);
        `CHK("suppress cleared", 1'b1, drv.charge_on)
        wr(8'h16, 16'h0000);
        rd_st();
        `CHK("alarm set", 1'b1, rd[12])
        wr(8'h14, 16'h0400);
        rd_st();
        `CHK("alarm cleared", 1'b0, rd[12])
        wr(8'h16, 16'h0000);
        wr(8'h12, 16'h0404);
        rd_st();
        `CHK("restore status", 16'hC400, rd)
        `CHK("restore vdac", 11'h480, drv.vdac)
        `CHK("restore idac", 6'h03, drv.idac)
        tdone("mode");
        set_cmp(8'hAA);
        set_cmp(8'hA8);
        rd_st();
        `CHK("hot latched", 1'b1, rd[9])
        wr(8'h12, 16'h0404);
        rd_st();
        `CHK("hot cleared", 1'b0, rd[9])
        set_cmp(8'hB0);
        `CHK("uv cap", 1'b1, drv.current_cap)
        set_cmp(8'hA0);
        `CHK("uv hysteresis", 1'b1, drv.current_cap)
        set_cmp(8'hA8);
        `CHK("uv release", 1'b0, drv.current_cap)
        `CHK("uv setpoint kept", 6'h03, drv.idac)
        tdone("thermal and undervoltage");
        wr(8'h12, 16'h0000);
        rd_st();
        `CHK("halt cleared", 1'b0, rd[10])
        set_cmp(8'h80);
        rd_st();
        `CHK("halt restored", 16'h8400, rd)
        `CHK("float mode", 1'b1, drv.float_mode)
        `CHK("float vdac", 11'h479, drv.vdac)
        `CHK("float cap", 1'b1, drv.current_cap)
        set_cmp(8'hA8);
        `CHK("regs reset", 1'b0, drv.charge_on)
        host.addr = 7'h0A;
        wr(8'h15, 16'h3000);
        host.addr = 7'h09;
        `CHK("foreign address", 1'b0, ok)
        `CHK("foreign ignored", 11'h000, drv.vdac)
        wr(8'h15, 16'h3000);
        set_cmp(8'hAC);
        wr(8'h14, 16'h0400);
        `CHK("vdd low ack", 1'b0, ok)
        `CHK("vdd low charge", 1'b0, drv.charge_on)
        set_cmp(8'hA8);
        `CHK("vdd recovery", 11'h000, drv.vdac)
        tdone("removal and refusals");
        complete_run();
    end
endmodule : tb
`default_nettype wire
